// ---- pkg/adc_seq_pkg.sv ----
package adc_seq_pkg;

   // register bus geometry
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned RES_W = 10;
   localparam int unsigned RES_NUM = 8;

   // register word offsets
   localparam logic [3:0] OFS_CTRL_A = 4'h0;
   localparam logic [3:0] OFS_CTRL_B = 4'h1;
   localparam logic [3:0] OFS_CTRL_C = 4'h2;
   localparam logic [3:0] OFS_RES_BASE = 4'h8;

   // converter_control_reg_a fields
   localparam int unsigned CA_CHAN_LSB = 0;
   localparam int unsigned CA_MODE_LSB = 3;
   localparam int unsigned CA_TRIG_BIT = 5;
   localparam int unsigned CA_START_BIT = 6;

   // converter_control_reg_b fields
   localparam int unsigned CB_SWEEP_LSB = 0;
   localparam int unsigned CB_EXT_LSB = 2;
   localparam int unsigned CB_STBY_BIT = 5;

   // converter_control_reg_c fields
   localparam int unsigned CC_GROUP_LSB = 1;
   localparam int unsigned CC_BUSY_BIT = 7;
   localparam logic [7:0] CC_WR_MASK = 8'h06;

   // reset values
   localparam logic [7:0] CTRL_A_RST = 8'h00;
   localparam logic [7:0] CTRL_B_RST = 8'h00;
   localparam logic [7:0] CTRL_C_RST = 8'h00;

   // operation mode encodings
   localparam logic [1:0] MODE_ONE_SHOT = 2'h0;
   localparam logic [1:0] MODE_REPEAT = 2'h1;
   localparam logic [1:0] MODE_SWEEP = 2'h2;
   localparam logic [1:0] MODE_RSWEEP = 2'h3;

   // extended input select encodings
   localparam logic [1:0] EXT_NONE = 2'h0;
   localparam logic [1:0] EXT_IN0 = 2'h1;
   localparam logic [1:0] EXT_IN1 = 2'h2;

   // input group encodings
   localparam logic [1:0] GRP_PRIMARY = 2'h0;
   localparam logic [1:0] GRP_ALT_A = 2'h1;
   localparam logic [1:0] GRP_ALT_B = 2'h2;

   // timing: converter clock is the system clock divided by AD_DIV
   localparam logic [1:0] AD_DIV = 2'h2;
   localparam logic [5:0] START_DUMMY_AD = 6'h01;
   localparam logic [5:0] CONV_AD = 6'h28;
   localparam logic [5:0] GAP_AD = 6'h01;
   localparam logic [5:0] END_DUMMY_FAD = 6'h02;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ARM = 3'b001,
      ST_START = 3'b010,
      ST_CONV = 3'b011,
      ST_GAP = 3'b100,
      ST_END = 3'b101
   } seq_state_t;

endpackage

// ---- core/result_store.sv ----
module result_store (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // write side
   input wire logic wr_en,
   input wire logic [2:0] wr_idx,
   input wire logic [adc_seq_pkg::RES_W-1:0] wr_data,
   // read side
   input wire logic rd_en,
   input wire logic [2:0] rd_idx,
   output logic [adc_seq_pkg::RES_W-1:0] rd_data_ff
);

   typedef struct packed {
      logic [adc_seq_pkg::RES_NUM-1:0][adc_seq_pkg::RES_W-1:0] mem;
      logic [adc_seq_pkg::RES_W-1:0] rd;
   } store_t;

   store_t s_ff;
   store_t nxt_s;

   always_comb begin
      nxt_s = s_ff;
      if (wr_en) begin
         nxt_s.mem[wr_idx] = wr_data;
      end
      if (rd_en) begin
         nxt_s.rd = s_ff.mem[rd_idx];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign rd_data_ff = s_ff.rd;

endmodule // result_store

// ---- core/adc_sweep_seq.sv ----
module adc_sweep_seq (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // register port
   input wire logic [adc_seq_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [adc_seq_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [adc_seq_pkg::DATA_W-1:0] reg_rdata,
   // external trigger pin
   input wire logic external_trigger_pin,
   // analog front end
   output logic [1:0] ana_group,
   output logic [2:0] ana_chan,
   output logic [1:0] ana_ext_sel,
   output logic sample_start,
   input wire logic [adc_seq_pkg::RES_W-1:0] sar_result,
   // completion request
   output logic conv_done_irq
);

   typedef struct packed {
      logic [7:0] ctrl_a;
      logic [7:0] ctrl_b;
      logic [7:0] ctrl_c;
      adc_seq_pkg::seq_state_t state;
      logic [5:0] cnt;
      logic [1:0] div;
      logic [2:0] pos;
      logic [2:0] trigger_select;
      logic trg_lvl;
      logic [adc_seq_pkg::DATA_W-1:0] rdata;
      logic rd_mem;
      logic [adc_seq_pkg::RES_W-1:0] res_hold;
      logic [2:0] hold_idx;
      logic sample;
      logic irq;
      logic [6:0] conv_cyc;
   } seq_regs_t;

   seq_regs_t s_ff;
   seq_regs_t nxt_s;

   logic tick;
   logic fall;
   logic conv_last_tick;
   logic sweep_mode;
   logic last_pos;
   logic res_we;
   logic [2:0] res_widx;
   logic [adc_seq_pkg::RES_W-1:0] res_wdata;
   logic [adc_seq_pkg::RES_W-1:0] mem_rd;
   logic [1:0] mode;
   logic [1:0] ext_sel;
   logic start_flag;

   // last channel index of a sweep set: 1, 3, 5 or 7
   function automatic logic [2:0] sweep_last(input logic [1:0] sel);
      sweep_last = {sel, 1'b1};
   endfunction

   // result register of the channel now converting
   function automatic logic [2:0] res_index(input logic [1:0] md, input logic [1:0] ext,
                                            input logic [2:0] p);
      res_index = p;
      if (md != adc_seq_pkg::MODE_SWEEP && md != adc_seq_pkg::MODE_RSWEEP) begin
         if (ext == adc_seq_pkg::EXT_IN0) begin
            res_index = 3'h0;
         end else if (ext == adc_seq_pkg::EXT_IN1) begin
            res_index = 3'h1;
         end
      end
   endfunction

   assign mode = s_ff.ctrl_a[adc_seq_pkg::CA_MODE_LSB +: 2];
   assign ext_sel = s_ff.ctrl_b[adc_seq_pkg::CB_EXT_LSB +: 2];
   assign start_flag = s_ff.ctrl_a[adc_seq_pkg::CA_START_BIT];
   assign sweep_mode = (mode == adc_seq_pkg::MODE_SWEEP) || (mode == adc_seq_pkg::MODE_RSWEEP);
   assign tick = (s_ff.div == adc_seq_pkg::AD_DIV - 2'h1);
   assign conv_last_tick = (s_ff.state == adc_seq_pkg::ST_CONV) && tick &&
                           (s_ff.cnt == adc_seq_pkg::CONV_AD - 6'h01);
   assign last_pos = !sweep_mode ||
                     (s_ff.pos == sweep_last(s_ff.ctrl_b[adc_seq_pkg::CB_SWEEP_LSB +: 2]));
   // falling edge of the stable level from stages two and three
   assign fall = (s_ff.trigger_select[1] == s_ff.trigger_select[2]) && !s_ff.trigger_select[2] && s_ff.trg_lvl;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.sample = 1'b0;
      nxt_s.irq = 1'b0;
      nxt_s.rd_mem = 1'b0;
      res_we = 1'b0;
      res_widx = res_index(mode, ext_sel, s_ff.pos);
      res_wdata = sar_result;
      nxt_s.div = tick ? 2'h0 : s_ff.div + 2'h1;
      nxt_s.trigger_select = {s_ff.trigger_select[1:0], external_trigger_pin};
      if (s_ff.trigger_select[1] == s_ff.trigger_select[2]) begin
         nxt_s.trg_lvl = s_ff.trigger_select[2];
      end
      nxt_s.conv_cyc = (s_ff.state == adc_seq_pkg::ST_CONV) ? s_ff.conv_cyc + 7'h01 : 7'h00;

      unique case (s_ff.state)
         adc_seq_pkg::ST_IDLE: begin
            if (start_flag && s_ff.ctrl_b[adc_seq_pkg::CB_STBY_BIT]) begin
               nxt_s.cnt = 6'h00;
               nxt_s.pos = sweep_mode ? 3'h0 : s_ff.ctrl_a[adc_seq_pkg::CA_CHAN_LSB +: 3];
               nxt_s.state = s_ff.ctrl_a[adc_seq_pkg::CA_TRIG_BIT] ?
                             adc_seq_pkg::ST_ARM : adc_seq_pkg::ST_START;
            end
         end
         adc_seq_pkg::ST_ARM: begin
            if (fall) begin
               nxt_s.state = adc_seq_pkg::ST_START;
            end
         end
         adc_seq_pkg::ST_START: begin
            if (tick) begin
               nxt_s.cnt = s_ff.cnt + 6'h01;
               if (s_ff.cnt == adc_seq_pkg::START_DUMMY_AD - 6'h01) begin
                  nxt_s.cnt = 6'h00;
                  nxt_s.sample = 1'b1;
                  nxt_s.state = adc_seq_pkg::ST_CONV;
               end
            end
         end
         adc_seq_pkg::ST_CONV: begin
            if (tick) begin
               nxt_s.cnt = s_ff.cnt + 6'h01;
            end
            if (conv_last_tick) begin
               nxt_s.cnt = 6'h00;
               if (mode == adc_seq_pkg::MODE_REPEAT) begin
                  res_we = 1'b1;
                  nxt_s.state = adc_seq_pkg::ST_GAP;
               end else if (mode == adc_seq_pkg::MODE_RSWEEP) begin
                  res_we = 1'b1;
                  nxt_s.pos = last_pos ? 3'h0 : s_ff.pos + 3'h1;
                  nxt_s.state = adc_seq_pkg::ST_GAP;
               end else if (!last_pos) begin
                  res_we = 1'b1;
                  nxt_s.pos = s_ff.pos + 3'h1;
                  nxt_s.state = adc_seq_pkg::ST_GAP;
               end else begin
                  // final result is held for the end dummy time
                  nxt_s.res_hold = sar_result;
                  nxt_s.hold_idx = res_index(mode, ext_sel, s_ff.pos);
                  nxt_s.state = adc_seq_pkg::ST_END;
               end
            end
         end
         adc_seq_pkg::ST_GAP: begin
            if (tick) begin
               nxt_s.cnt = s_ff.cnt + 6'h01;
               if (s_ff.cnt == adc_seq_pkg::GAP_AD - 6'h01) begin
                  nxt_s.cnt = 6'h00;
                  nxt_s.sample = 1'b1;
                  nxt_s.state = adc_seq_pkg::ST_CONV;
               end
            end
         end
         adc_seq_pkg::ST_END: begin
            nxt_s.cnt = s_ff.cnt + 6'h01;
            if (s_ff.cnt == adc_seq_pkg::END_DUMMY_FAD - 6'h01) begin
               res_we = 1'b1;
               res_widx = s_ff.hold_idx;
               res_wdata = s_ff.res_hold;
               nxt_s.ctrl_a[adc_seq_pkg::CA_START_BIT] = 1'b0;
               nxt_s.irq = (mode == adc_seq_pkg::MODE_SWEEP);
               nxt_s.cnt = 6'h00;
               nxt_s.state = adc_seq_pkg::ST_IDLE;
            end
         end
         default: begin
            nxt_s.state = adc_seq_pkg::ST_IDLE;
         end
      endcase

      if (!start_flag && s_ff.state != adc_seq_pkg::ST_IDLE) begin
         nxt_s.state = adc_seq_pkg::ST_IDLE;
         nxt_s.cnt = 6'h00;
         nxt_s.sample = 1'b0;
         res_we = 1'b0;
      end

      // a software write wins over the self clear
      if (reg_wr) begin
         unique case (reg_addr)
            adc_seq_pkg::OFS_CTRL_A: nxt_s.ctrl_a = reg_wdata[7:0];
            adc_seq_pkg::OFS_CTRL_B: nxt_s.ctrl_b = reg_wdata[7:0];
            adc_seq_pkg::OFS_CTRL_C: nxt_s.ctrl_c = reg_wdata[7:0] & adc_seq_pkg::CC_WR_MASK;
            default: begin
            end
         endcase
      end

      nxt_s.rdata = '0;
      if (reg_rd) begin
         if (reg_addr >= adc_seq_pkg::OFS_RES_BASE) begin
            nxt_s.rd_mem = 1'b1;
         end else if (reg_addr == adc_seq_pkg::OFS_CTRL_A) begin
            nxt_s.rdata = {8'h00, s_ff.ctrl_a};
         end else if (reg_addr == adc_seq_pkg::OFS_CTRL_B) begin
            nxt_s.rdata = {8'h00, s_ff.ctrl_b};
         end else if (reg_addr == adc_seq_pkg::OFS_CTRL_C) begin
            nxt_s.rdata = {8'h00, s_ff.ctrl_c};
            nxt_s.rdata[adc_seq_pkg::CC_BUSY_BIT] = (s_ff.state != adc_seq_pkg::ST_IDLE);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   result_store u_store (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .wr_en(res_we),
      .wr_idx(res_widx),
      .wr_data(res_wdata),
      .rd_en(reg_rd),
      .rd_idx(reg_addr[2:0]),
      .rd_data_ff(mem_rd)
   );

   assign reg_rdata = s_ff.rd_mem ? {6'h00, mem_rd} : s_ff.rdata;
   assign ana_group = s_ff.ctrl_c[adc_seq_pkg::CC_GROUP_LSB +: 2];
   assign ana_chan = s_ff.pos;
   assign ana_ext_sel = sweep_mode ? adc_seq_pkg::EXT_NONE : ext_sel;
   assign sample_start = s_ff.sample;
   assign conv_done_irq = s_ff.irq;

   sequence s_conv_end;
      conv_last_tick && start_flag;
   endsequence

   sequence s_gap_to_conv;
      (s_ff.state == adc_seq_pkg::ST_GAP) ##[1:2] (s_ff.state == adc_seq_pkg::ST_CONV);
   endsequence

   AST_REPEAT_AGAIN: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_conv_end ##0 (mode == adc_seq_pkg::MODE_REPEAT) ##0 !reg_wr ##1 !reg_wr
      |-> s_gap_to_conv ##0 sample_start && ana_chan == $past(ana_chan, 3))
      else $error("repeat mode did not restart the same channel");

   AST_SW_START: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_ff.state == adc_seq_pkg::ST_IDLE && start_flag && !reg_wr &&
      s_ff.ctrl_b[adc_seq_pkg::CB_STBY_BIT] && !s_ff.ctrl_a[adc_seq_pkg::CA_TRIG_BIT]
      |=> s_ff.state == adc_seq_pkg::ST_START ##[1:2] sample_start)
      else $error("software trigger did not start conversion");

   AST_EXT_WAIT: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_ff.state == adc_seq_pkg::ST_ARM && !fall |=> s_ff.state != adc_seq_pkg::ST_START)
      else $error("external trigger start without falling edge");

   AST_NO_SELF_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (mode == adc_seq_pkg::MODE_REPEAT || mode == adc_seq_pkg::MODE_RSWEEP) &&
      start_flag && !reg_wr |=> start_flag)
      else $error("start flag cleared without software write");

   AST_NO_IRQ: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (mode == adc_seq_pkg::MODE_REPEAT || mode == adc_seq_pkg::MODE_RSWEEP) &&
      $stable(mode) |-> !conv_done_irq)
      else $error("interrupt raised in a repeat mode");

   AST_SWEEP_END: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_conv_end ##0 (mode == adc_seq_pkg::MODE_SWEEP && last_pos) ##0 !reg_wr
      |=> (start_flag && !reg_wr)[*2] ##1 !start_flag && conv_done_irq)
      else $error("single sweep did not end with flag clear and interrupt");

   AST_IRQ_CAUSE: assert property (@(posedge sys_clk) disable iff (!rst_b)
      conv_done_irq |-> $past(s_ff.state) == adc_seq_pkg::ST_END &&
      mode == adc_seq_pkg::MODE_SWEEP)
      else $error("interrupt without single sweep completion");

   AST_CONV_LEN: assert property (@(posedge sys_clk) disable iff (!rst_b)
      conv_last_tick |->
      s_ff.conv_cyc == 7'(adc_seq_pkg::CONV_AD) * 7'(adc_seq_pkg::AD_DIV) - 7'h01)
      else $error("conversion length not forty converter cycles");

   AST_SWEEP_WRAP: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_conv_end ##0 (mode == adc_seq_pkg::MODE_RSWEEP && last_pos) ##0 !reg_wr
      |=> ana_chan == 3'h0 && res_we == 1'b0)
      else $error("repeat sweep did not wrap to the first channel");

   AST_RES_INDEX: assert property (@(posedge sys_clk) disable iff (!rst_b)
      res_we && sweep_mode && s_ff.state == adc_seq_pkg::ST_CONV |-> res_widx == s_ff.pos)
      else $error("result stored in wrong register");

endmodule // adc_sweep_seq

// ---- verification/afe_model.sv ----
module afe_model (
   // clock
   input wire logic sys_clk,
   // selection from the sequencer
   input wire logic [1:0] ana_group,
   input wire logic [2:0] ana_chan,
   input wire logic [1:0] ana_ext_sel,
   input wire logic sample_start,
   // converted value
   output logic [adc_seq_pkg::RES_W-1:0] sar_result
);
   timeunit 1ns;
   timeprecision 1ps;
   // value encodes the input that is selected, so a wrong route shows up
   assign sar_result = {ana_group, ana_ext_sel, ana_chan, 3'h5};
endmodule // afe_model

// ---- verification/testbench.sv ----
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, rst_b, reg_wr, reg_rd, external_trigger_pin, sample_start, conv_done_irq;
   logic [adc_seq_pkg::ADDR_W-1:0] reg_addr;
   logic [adc_seq_pkg::DATA_W-1:0] reg_wdata, reg_rdata;
   logic [1:0] ana_group, ana_ext_sel;
   logic [2:0] ana_chan;
   logic [adc_seq_pkg::RES_W-1:0] sar_result;
   logic [2:0] chans[$];
   logic [1:0] exts[$];
   int n_errors, total_checks, n_starts, n_irq, cyc, last, gap;

   adc_sweep_seq dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .external_trigger_pin(external_trigger_pin), .ana_group(ana_group),
      .ana_chan(ana_chan), .ana_ext_sel(ana_ext_sel), .sample_start(sample_start),
      .sar_result(sar_result), .conv_done_irq(conv_done_irq));
   afe_model afe (.sys_clk(sys_clk), .ana_group(ana_group), .ana_chan(ana_chan),
      .ana_ext_sel(ana_ext_sel), .sample_start(sample_start), .sar_result(sar_result));

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // records every conversion start and completion pulse
   always @(posedge sys_clk) begin
      cyc++;
      if (sample_start === 1'b1) begin
         chans.push_back(ana_chan);
         exts.push_back(ana_ext_sel);
         gap = cyc - last;
         last = cyc;
         n_starts++;
      end
      if (rst_b === 1'b1 && conv_done_irq !== 1'b0) n_irq++;
   end

   function logic [15:0] exp_res(input logic [1:0] g, input logic [1:0] e, input logic [2:0] c);
      exp_res = {6'h00, g, e, c, 3'h5};
   endfunction

   task summarize;
      if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task chk_val(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask

   task chk_int(input int got, input int exp);
      total_checks++;
      if (got != exp) begin
         n_errors++;
         $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
      end
   endtask

   task reg_write(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task reg_read(input logic [3:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task read_chk(input logic [3:0] a, input logic [15:0] exp);
      logic [15:0] d;
      reg_read(a, d);
      chk_val(d, exp);
   endtask

   task clr;
      n_starts = 0;
      n_irq = 0;
      chans.delete();
      exts.delete();
   endtask

   task wait_for(input int n, input int irqs, input int lim);
      for (int i = 0; i < lim && (n_starts < n || n_irq < irqs); i++) @(posedge sys_clk);
   endtask

   task t_reset;
      read_chk(4'h0, 16'h0000);
      read_chk(4'h2, 16'h0000);
      read_chk(4'h8, 16'h0000);
      read_chk(4'h3, 16'h0000);
      chk_int(n_starts + n_irq, 0);
   endtask

   task t_sweep(input int s, input logic [1:0] g);
      int n;
      n = 2 * (s + 1);
      reg_write(4'h1, 16'h0020 | 16'(s));
      reg_write(4'h2, {13'h0000, g, 1'b0});
      // standby settle before start
      repeat (2) @(posedge sys_clk);
      clr();
      reg_write(4'h0, 16'h0050);
      wait_for(n, 1, 90 * n + 40);
      repeat (3) @(posedge sys_clk);
      chk_int(n_starts, n);
      chk_int(n_irq, 1);
      for (int i = 0; i < n; i++) chk_val({13'h0000, chans[i]}, 16'(i));
      chk_int(gap, 82);
      read_chk(4'h0, 16'h0010);
      for (int i = 0; i < n; i++) read_chk(4'(8 + i), exp_res(g, 2'h0, 3'(i)));
   endtask

   task t_repeat;
      reg_write(4'h1, 16'h0020);
      reg_write(4'h2, 16'h0002);
      clr();
      reg_write(4'h0, 16'h004D);
      wait_for(3, 0, 300);
      chk_int(n_starts, 3);
      chk_int(gap, 82);
      chk_int(n_irq, 0);
      chk_val({13'h0000, chans[2]}, 16'h0005);
      read_chk(4'h0, 16'h004D);
      read_chk(4'hD, exp_res(2'h1, 2'h0, 3'h5));
      reg_write(4'h0, 16'h000D);
      repeat (3) @(posedge sys_clk);
      read_chk(4'h2, 16'h0002);
      clr();
      repeat (200) @(posedge sys_clk);
      chk_int(n_starts, 0);
   endtask

   task t_ext_input;
      reg_write(4'h1, 16'h0024);
      clr();
      reg_write(4'h0, 16'h0048);
      wait_for(2, 0, 200);
      chk_int(n_starts, 2);
      chk_val({14'h0000, exts[1]}, 16'h0001);
      read_chk(4'h8, exp_res(2'h1, 2'h1, 3'h0));
      reg_write(4'h0, 16'h0008);
   endtask

   task t_rsweep;
      // control registers are rewritten only once the sequencer is idle
      read_chk(4'h2, 16'h0002);
      reg_write(4'h1, 16'h0020);
      reg_write(4'h2, 16'h0000);
      clr();
      reg_write(4'h0, 16'h0058);
      wait_for(5, 0, 450);
      for (int i = 0; i < 5; i++) chk_val({13'h0000, chans[i]}, 16'(i % 2));
      chk_int(n_irq, 0);
      read_chk(4'h0, 16'h0058);
      reg_write(4'h0, 16'h0018);
   endtask

   task t_trigger;
      reg_write(4'h1, 16'h0020);
      reg_write(4'h0, 16'h0030);
      clr();
      external_trigger_pin <= 1'b0;
      repeat (20) @(posedge sys_clk);
      external_trigger_pin <= 1'b1;
      reg_write(4'h0, 16'h0070);
      repeat (20) @(posedge sys_clk);
      chk_int(n_starts, 0);
      external_trigger_pin <= 1'b0;
      wait_for(1, 0, 12);
      chk_int(n_starts, 1);
      wait_for(2, 1, 200);
      chk_int(n_irq, 1);
      external_trigger_pin <= 1'b1;
      reg_write(4'h0, 16'h0010);
   endtask

   task t_abort;
      reg_write(4'h1, 16'h0023);
      clr();
      reg_write(4'h0, 16'h0050);
      wait_for(1, 0, 20);
      reg_write(4'h0, 16'h0010);
      repeat (200) @(posedge sys_clk);
      chk_int(n_starts, 1);
      chk_int(n_irq, 0);
      read_chk(4'h2, 16'h0000);
      // one-shot: one conversion of channel 5, then the flag clears itself
      clr();
      reg_write(4'h0, 16'h0045);
      wait_for(1, 0, 20);
      repeat (100) @(posedge sys_clk);
      chk_int(n_starts, 1);
      chk_int(n_irq, 0);
      read_chk(4'h0, 16'h0005);
      read_chk(4'hD, exp_res(2'h0, 2'h0, 3'h5));
   endtask

   initial begin
      rst_b = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      external_trigger_pin = 1'b1;
      repeat (3) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_reset();
      for (int s = 0; s < 4; s++) t_sweep(s, 2'(s % 3));
      t_repeat();
      t_ext_input();
      t_rsweep();
      t_trigger();
      t_abort();
      summarize();
   end

   initial begin
      #(20000 * 50);
      n_errors++;
      summarize();
   end
endmodule // testbench
